// *** hw/temp_link_pkg.sv ***
// shared constants for the temperature sensor serial link and its host
package temp_link_pkg;
  localparam int unsigned CLK_MHZ = 250; // mclk rate in MHz
  localparam int unsigned CONV_PERIOD_US = 350; // autoconversion interval, us
  localparam int unsigned CONV_TIME_US = 25; // one conversion, us
  localparam int unsigned SPACE_PCT = 130; // host select spacing, percent of the interval
  localparam int unsigned CONV_PERIOD_CYC = CONV_PERIOD_US * CLK_MHZ; // interval in mclk cycles
  localparam int unsigned CONV_TIME_CYC = CONV_TIME_US * CLK_MHZ; // conversion in mclk cycles
  localparam int unsigned SPACE_CYC = CONV_PERIOD_CYC * SPACE_PCT / 100; // host spacing in cycles
  localparam int unsigned FRAME_BITS = 16; // clock pulses per frame
  localparam int unsigned RESULT_W = 10; // result width
  localparam int unsigned CTRL_W = 8; // control register width
  localparam int unsigned TIMER_W = 17; // wide enough for every cycle count above
  localparam int unsigned CNT_W = 5; // bit counters
  localparam int unsigned DIV_W = 8; // serial clock divider
  localparam int unsigned HALF_DEF = 4; // half serial clock period in mclk cycles
  localparam int unsigned RAW_LSB = 5; // result lsb position inside the 16-bit frame
  localparam logic [CTRL_W-1:0] CTRL_WORD = 8'h00; // control word, all bits low
  // host register map, byte offsets
  localparam logic [7:0] REG_CMD = 8'h00; // write: start a frame
  localparam logic [7:0] REG_STATUS = 8'h04; // read: busy, done; write 1 clears done
  localparam logic [7:0] REG_RESULT = 8'h08; // read: last 10-bit result
  localparam logic [7:0] REG_RAW = 8'h0C; // read: last raw 16-bit frame
  localparam int unsigned CMD_START_BIT = 0; // start bit in REG_CMD
  localparam int unsigned STAT_BUSY_BIT = 0; // busy bit in REG_STATUS
  localparam int unsigned STAT_DONE_BIT = 1; // done bit in REG_STATUS
endpackage : temp_link_pkg

// *** hw/temp_link_if.sv ***
// serial wires between the temperature sensor end and its host
`timescale 1ns/1ps
interface temp_link_if;
  logic temp_select_n; // active-low temperature select
  logic sclk; // serial shift clock from host
  logic din; // host to sensor data
  logic dout_o; // sensor output value
  logic dout_oe; // sensor drives dout while high
  logic dout; // resolved line seen by the host
  // a released line reads as pulled high
  assign dout = dout_oe ? dout_o : 1'b1;
  modport dev (input temp_select_n, input sclk, input din, output dout_o, output dout_oe);
  modport host (output temp_select_n, output sclk, output din, input dout);
endinterface : temp_link_if

// *** hw/pin_sync.sv ***
// two-flop synchroniser for pins from outside the mclk domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1, // number of pins
  parameter logic [W-1:0] RST_VAL = '0 // idle level of the pins
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [W-1:0] d, // raw pins
  output logic [W-1:0] q // synchronised pins
);
  typedef struct packed {
    logic [W-1:0] meta; // first stage, read only by the second
    logic [W-1:0] stab; // second stage
  } sync_s;
  sync_s s_q;
  sync_s s_d;

  // next state
  always_comb begin
    s_d.meta = d;
    s_d.stab = s_q.meta;
  end

  // registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= {RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stab;
endmodule : pin_sync

// *** hw/temp_sensor_end.sv ***
// temperature sensor end: autoconversion timer, update lockout and serial port
`timescale 1ns/1ps
// Contract
// - select low enables 16-clock frame, zero plus result
// - hold last bit until select rises, then release
// - shift din into control register on rising clocks
// - host keeps din low during the frame
// - control register eight bits, all written low
// - result is twos complement, quarter degree steps
// - codes follow the signed scale over range
// - conversion starts every 350 us internally
// - conversion lasts 25 us, then sensor sleeps
// - output register holds latest finished conversion
// - interval timer starts when conversion finishes
// - access during conversion sets update lockout
// - lockout clears only at next autoconversion start
// - frequent selects return the same unchanged value
// - host spaces select falls beyond the interval
// - end of access restarts the conversion timer
// - read before restarted conversion ends repeats data
// - timing from internal clock, sclk only shifts
// - host captures frame as two bytes or one
// - host never selects accelerometer and temperature together
// - output bits change on falling shift clock
module temp_sensor_end
  import temp_link_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = CONV_PERIOD_CYC, // cycles between autoconversions
  parameter int unsigned CONV_CYC = CONV_TIME_CYC // cycles of one conversion
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  temp_link_if.dev link, // serial wires
  input wire logic [RESULT_W-1:0] temp_sample, // converter code, twos complement
  output logic [RESULT_W-1:0] result, // temperature value register
  output logic [CTRL_W-1:0] ctrl_word, // last control bits shifted in
  output logic converting, // conversion running
  output logic lockout // update lockout
);
  typedef enum logic {
    CV_WAIT, // asleep, interval timer counting
    CV_RUN // converting
  } conv_e;

  typedef struct packed {
    conv_e conv; // conversion phase
    logic [TIMER_W-1:0] timer; // interval or conversion count
    logic lockout; // blocks the result update
    logic [RESULT_W-1:0] result; // temperature value register
    logic sel_prev; // select one cycle ago
    logic sclk_prev; // shift clock one cycle ago
    logic [RESULT_W:0] shreg; // leading zero plus result
    logic [CNT_W-1:0] out_cnt; // bits shifted out after the leading zero
    logic [CNT_W-1:0] in_cnt; // rising clocks seen this frame
    logic [CTRL_W-1:0] ctrl; // control register
    logic dout_o; // serial output level
    logic dout_oe; // serial output driven
  } dev_s;

  dev_s q;
  dev_s d;
  logic [2:0] pins_s; // synchronised select, sclk, din
  logic sel_n; // select, synchronised
  logic sclk_s; // shift clock, synchronised
  logic din_s; // serial input, synchronised
  logic sel_fall; // frame opens
  logic sel_rise; // frame closes
  logic sclk_rise; // rising shift clock seen
  logic sclk_fall; // falling shift clock seen

  // all link pins cross into mclk before any logic looks at them
  pin_sync #(
    .W(3),
    .RST_VAL(3'h4)
  ) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .d({link.temp_select_n, link.sclk, link.din}),
    .q(pins_s)
  );

  assign sel_n = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[0];

  // edge detection on the synchronised copies only
  assign sel_fall = q.sel_prev & ~sel_n;
  assign sel_rise = ~q.sel_prev & sel_n;
  assign sclk_rise = ~sel_n & ~q.sclk_prev & sclk_s;
  assign sclk_fall = ~sel_n & q.sclk_prev & ~sclk_s;

  // next state: conversion sequencer, lockout, then the shift port
  always_comb begin
    d = q;
    d.sel_prev = sel_n;
    d.sclk_prev = sclk_s;

    // the sequencer runs from mclk alone; the shift clock never advances it
    case (q.conv)
      CV_WAIT: begin
        if (q.timer == TIMER_W'(PERIOD_CYC - 1)) begin
          d.conv = CV_RUN;
          d.timer = '0;
          // only the automatic start may drop the lockout
          if (sel_n) begin
            d.lockout = 1'b0;
          end
        end else begin
          d.timer = q.timer + 1'b1;
        end
      end
      CV_RUN: begin
        if (q.timer == TIMER_W'(CONV_CYC - 1)) begin
          d.conv = CV_WAIT;
          d.timer = '0;
          // a locked conversion is thrown away, keeping the old value
          if (!q.lockout) begin
            d.result = temp_sample;
          end
        end else begin
          d.timer = q.timer + 1'b1;
        end
      end
      default: begin
        d.conv = CV_WAIT;
        d.timer = '0;
      end
    endcase

    // end of an access restarts the oscillator and a conversion
    if (sel_rise) begin
      d.conv = CV_RUN;
      d.timer = '0;
    end

    // selected while converting: lock the update; set wins over clear
    if (!sel_n && d.conv == CV_RUN) begin
      d.lockout = 1'b1;
    end

    // frame open: load snapshot and drive the leading zero at once
    if (sel_fall) begin
      d.shreg = {1'b0, q.result};
      d.out_cnt = '0;
      d.in_cnt = '0;
      d.dout_o = 1'b0;
      d.dout_oe = 1'b1;
    end else begin
      // control bits enter on rising clocks, beyond 16 they are ignored
      if (sclk_rise && q.in_cnt != CNT_W'(FRAME_BITS)) begin
        d.ctrl = {q.ctrl[CTRL_W-2:0], din_s};
        d.in_cnt = q.in_cnt + 1'b1;
      end
      // next result bit on each falling clock; after the lsb the line holds
      if (sclk_fall && q.out_cnt != CNT_W'(RESULT_W)) begin
        d.dout_o = q.shreg[RESULT_W-1];
        d.shreg = {q.shreg[RESULT_W-1:0], 1'b0};
        d.out_cnt = q.out_cnt + 1'b1;
      end
    end

    // last bit stands until select rises, then the line is released
    if (sel_rise) begin
      d.dout_oe = 1'b0;
    end
  end

  // state register; the sensor starts asleep with a zero result
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{conv: CV_WAIT, timer: '0, lockout: 1'b0, result: '0, sel_prev: 1'b1,
             sclk_prev: 1'b0, shreg: '0, out_cnt: '0, in_cnt: '0, ctrl: CTRL_WORD,
             dout_o: 1'b0, dout_oe: 1'b0};
    end else begin
      q <= d;
    end
  end

  // every output comes from the state register
  assign link.dout_o = q.dout_o;
  assign link.dout_oe = q.dout_oe;
  assign result = q.result;
  assign ctrl_word = q.ctrl;
  assign converting = (q.conv == CV_RUN);
  assign lockout = q.lockout;
endmodule : temp_sensor_end

// *** hw/temp_host_end.sv ***
// host end: AHB-Lite register slave driving temperature read frames
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module temp_host_end
  import temp_link_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_DEF, // half serial clock period, mclk cycles
  parameter int unsigned GAP_CYC = SPACE_CYC // least spacing of select falls
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  temp_link_if.host link // serial wires
);
  typedef enum logic [2:0] {
    H_IDLE, // waiting for start and spacing
    H_LEAD, // select low, clock low
    H_HIGH, // clock high
    H_LOW, // clock low between pulses
    H_TAIL // after last pulse, before select rises
  } host_e;

  typedef struct packed {
    host_e st; // frame phase
    logic [DIV_W-1:0] div; // half period divider
    logic [CNT_W-1:0] pulse; // pulses given
    logic [FRAME_BITS-1:0] shreg; // bits received
    logic [FRAME_BITS-1:0] raw; // last full frame
    logic [RESULT_W-1:0] result; // last result
    logic [TIMER_W-1:0] gap; // cycles since last select fall
    logic pending; // start requested
    logic done; // frame finished, sticky
    logic sel_n; // select pin
    logic sclk; // clock pin
    logic din; // data pin
    logic wr_pend; // write data phase due
    logic [7:0] wr_addr; // its offset
    logic [31:0] hrdata; // read data
  } host_s;

  host_s q;
  host_s d;
  logic dout_s; // returned data, synchronised
  logic ahb_go; // address phase accepted
  logic busy; // frame requested or running
  logic half_end; // last cycle of a half period

  // dout comes from the far clock domain
  pin_sync #(
    .W(1),
    .RST_VAL(1'h1)
  ) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .d(link.dout),
    .q(dout_s)
  );

  assign ahb_go = hsel & htrans[1] & hready;
  assign busy = q.pending | (q.st != H_IDLE);
  assign half_end = (q.div == DIV_W'(HALF_CYC - 1));

  // next state: bus slave, then frame sequencer
  always_comb begin
    d = q;
    // read data is fixed at the address phase, so the slave needs no wait
    if (ahb_go && !hwrite) begin
      case (haddr[7:0])
        REG_STATUS: d.hrdata = 32'({q.done, busy});
        REG_RESULT: d.hrdata = 32'(q.result);
        REG_RAW: d.hrdata = 32'(q.raw);
        default: d.hrdata = '0;
      endcase
    end
    d.wr_pend = ahb_go & hwrite;
    d.wr_addr = haddr[7:0];
    if (q.wr_pend && q.wr_addr == REG_CMD && hwdata[CMD_START_BIT]) begin
      d.pending = 1'b1;
    end
    if (q.wr_pend && q.wr_addr == REG_STATUS && hwdata[STAT_DONE_BIT]) begin
      d.done = 1'b0;
    end

    if (q.gap != TIMER_W'(GAP_CYC)) begin
      d.gap = q.gap + 1'b1;
    end
    d.div = half_end ? '0 : q.div + 1'b1;

    case (q.st)
      H_IDLE: begin
        d.div = '0;
        // the spacing keeps select falls over one interval apart; a start that lands in an autoconversion still sets the lockout
        if (q.pending && q.gap == TIMER_W'(GAP_CYC)) begin
          d.pending = 1'b0;
          // only the temperature select exists here, so no other select can join it
          d.sel_n = 1'b0;
          // control word is all zero, so din stays low for the whole frame
          d.din = CTRL_WORD[CTRL_W-1];
          d.gap = '0;
          d.pulse = '0;
          d.st = H_LEAD;
        end
      end
      H_LEAD, H_LOW: begin
        if (half_end) begin
          d.sclk = 1'b1;
          d.st = H_HIGH;
        end
      end
      H_HIGH: begin
        // sample late in the high phase, well after the sensor's fall update
        if (half_end) begin
          d.shreg = {q.shreg[FRAME_BITS-2:0], dout_s};
          d.sclk = 1'b0;
          d.pulse = q.pulse + 1'b1;
          d.st = (q.pulse == CNT_W'(FRAME_BITS - 1)) ? H_TAIL : H_LOW;
        end
      end
      H_TAIL: begin
        if (half_end) begin
          d.sel_n = 1'b1;
          d.raw = q.shreg;
          d.result = q.shreg[RAW_LSB +: RESULT_W];
          d.done = 1'b1; // set wins over a clear in the same cycle
          d.st = H_IDLE;
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  // state register; spacing starts satisfied so the first frame is immediate
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{st: H_IDLE, div: '0, pulse: '0, shreg: '0, raw: '0, result: '0,
             gap: TIMER_W'(GAP_CYC), pending: 1'b0, done: 1'b0, sel_n: 1'b1,
             sclk: 1'b0, din: 1'b0, wr_pend: 1'b0, wr_addr: '0, hrdata: '0};
    end else begin
      q <= d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign link.temp_select_n = q.sel_n;
  assign link.sclk = q.sclk;
  assign link.din = q.din;
endmodule : temp_host_end

// *** verif/temp_sensor_serial_readout_chk.sv ***
// concurrent checks on the temperature link wires and sensor state
`timescale 1ns/1ps
module temp_sensor_serial_readout_chk (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic temp_select_n, // sensor select
  input wire logic sclk, // shift clock
  input wire logic din, // host data
  input wire logic dout_o, // sensor drive value
  input wire logic dout_oe, // sensor drive enable
  input wire logic [9:0] result, // value register
  input wire logic converting, // conversion running
  input wire logic lockout // update lockout
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [4:0] rise_q; // sclk rises seen in this frame
  logic sclk_q; // sclk one cycle ago
  // count shift clock rises while selected, cleared between frames
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rise_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (temp_select_n) begin
        rise_q <= '0;
      end else if (sclk && !sclk_q) begin
        rise_q <= rise_q + 5'h01;
      end
    end
  end
  sequence frame_open;
    $fell(temp_select_n);
  endsequence
  sequence zero_driven;
    dout_oe && !dout_o;
  endsequence
  AST_LEAD_ZERO: assert property (frame_open |-> ##[1:6] zero_driven)
    else $error("leading zero not driven");
  AST_PULSES: assert property ($rose(temp_select_n) |-> rise_q == 5'h10)
    else $error("frame pulse count wrong");
  AST_RELEASE: assert property ($rose(temp_select_n) |-> ##[1:6] !dout_oe)
    else $error("output not released");
  // after eleven falls only the last bit remains, held to the end
  AST_HOLD: assert property (!temp_select_n && rise_q >= 5'h0C |-> dout_oe && $stable(dout_o))
    else $error("last bit not held");
  AST_SHIFT_EDGE: assert property (sclk && $past(sclk) && dout_oe |-> $stable(dout_o))
    else $error("output moved in high phase");
  AST_DIN_LOW: assert property (!temp_select_n |-> !din)
    else $error("din high in frame");
  AST_SCLK_IDLE: assert property (temp_select_n |-> !sclk)
    else $error("sclk outside frame");
  AST_LOCK_SET: assert property ((!temp_select_n && converting) [*5] |-> lockout)
    else $error("lockout not set");
  // the sensor sees select through two flops, so the clear follows the pin of three samples back
  AST_LOCK_CLEAR: assert property ($fell(lockout) |-> converting && $past(temp_select_n, 3))
    else $error("lockout cleared early");
  AST_FROZEN: assert property (lockout && $past(lockout) |-> $stable(result))
    else $error("result moved under lockout");
  AST_UPDATE: assert property ($changed(result) |-> $past(converting) && !converting)
    else $error("result moved off conversion end");
endmodule : temp_sensor_serial_readout_chk

// *** verif/temp_sensor_serial_readout_tb_top.sv ***
// self-checking bench: host and sensor ends joined by the serial link
`timescale 1ns/1ps
module temp_sensor_serial_readout_tb_top;
  import temp_link_pkg::*;
  logic mclk = 1'b0; // system clock
  logic arst_n = 1'b0; // reset, active low
  logic hsel = 1'b0; // bus select
  logic [31:0] haddr = '0; // bus address
  logic [1:0] htrans = 2'b00; // transfer type
  logic hwrite = 1'b0; // write strobe
  logic [2:0] hsize = 3'b010; // whole word
  logic [31:0] hwdata = '0; // write data
  logic hreadyout; // slave ready, also bus ready
  logic hresp; // slave response
  logic [31:0] hrdata; // read data
  logic [RESULT_W-1:0] temp_sample = '0; // converter code
  logic [RESULT_W-1:0] result; // sensor value register
  logic [CTRL_W-1:0] ctrl_word; // shifted control bits
  logic converting; // conversion running
  logic lockout; // update lockout
  logic sel_n; // copy of select for waits
  logic dphase = 1'b0; // read data phase in flight
  logic [31:0] exp_q[$]; // expected read data
  logic [31:0] msk_q[$]; // compared bits
  int err_count = 0; // mismatches
  int total_checks = 0; // comparisons
  int seed = 32'h05CE; // fixed seed
  logic [9:0] tbl [11] = '{10'h360, 10'h39C, 10'h3FF, 10'h000, 10'h001, 10'h028,
    10'h064, 10'h0C8, 10'h12C, 10'h190, 10'h1F4}; // signed scale points
  temp_link_if link ();
  // short counts keep the run small; spacing exceeds the interval but not frame plus interval
  temp_sensor_end #(.PERIOD_CYC(200), .CONV_CYC(20)) i_temp_sensor_end (.mclk(mclk), .arst_n(arst_n),
    .link(link), .temp_sample(temp_sample), .result(result), .ctrl_word(ctrl_word),
    .converting(converting), .lockout(lockout));
  temp_host_end #(.HALF_CYC(4), .GAP_CYC(300)) i_temp_host_end (.mclk(mclk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
  temp_sensor_serial_readout_chk i_temp_sensor_serial_readout_chk (.mclk(mclk), .arst_n(arst_n),
    .temp_select_n(link.temp_select_n), .sclk(link.sclk), .din(link.din), .dout_o(link.dout_o),
    .dout_oe(link.dout_oe), .result(result), .converting(converting), .lockout(lockout));
  always_comb sel_n = link.temp_select_n;
  // clock generator, 4 ns period
  initial begin
    forever #2 mclk = ~mclk;
  end
  // one comparison, counted
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // a wait that ran out counts as a mismatch and ends the run
  task automatic fail_out(input string nm);
    err_count++;
    $display("Error %s expected event seen timeout", nm);
    complete_run();
  endtask : fail_out
  // bounded wait for a level on select (sig 0) or on converting (sig 1)
  task automatic wait_lv(input int sig, input logic v, input int lim);
    int n;
    n = 0;
    while ((sig == 0 ? sel_n : converting) !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if ((sig == 0 ? sel_n : converting) !== v) fail_out("level");
  endtask : wait_lv
  // bounded wait for an edge with ready high
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) fail_out("hready");
  endtask : wait_ready
  // single word transfer; a read notes its expectation first
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
    input logic [31:0] m);
    if (!wr) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    dphase <= !wr;
    wait_ready();
    dphase <= 1'b0;
  endtask : bus
  // watcher: compare read data with the oldest note
  initial begin : watch
    logic [31:0] m;
    forever begin
      @(posedge mclk);
      if (dphase && hreadyout === 1'b1 && exp_q.size() > 0) begin
        m = msk_q.pop_front();
        check("hrdata", exp_q.pop_front(), hrdata & m);
      end
    end
  end
  // one host frame, then status, result, raw frame and done clearing
  task automatic frame(input logic [9:0] c);
    bus(1'b1, REG_CMD, 32'h1, '0, '0);
    wait_lv(0, 1'b0, 400);
    // busy must show while the frame runs, done was cleared by the last frame
    bus(1'b0, REG_STATUS, '0, 32'h1, 32'h3);
    wait_lv(0, 1'b1, 400);
    repeat (2) @(posedge mclk);
    bus(1'b0, REG_STATUS, '0, 32'h2, 32'h3);
    bus(1'b0, REG_RESULT, '0, {22'h0, c}, 32'h3FF);
    bus(1'b0, REG_RAW, '0, {16'h0, 1'b0, c, {5{c[0]}}}, 32'hFFFF);
    bus(1'b1, REG_STATUS, 32'h2, '0, '0);
    bus(1'b0, REG_STATUS, '0, 32'h0, 32'h3);
    check("ctrl_word", {24'h0, CTRL_WORD}, {24'h0, ctrl_word});
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : frame
  // load a code, let a conversion take it, read it just after
  task automatic fresh(input logic [9:0] c);
    temp_sample <= c;
    repeat (320) @(posedge mclk);
    wait_lv(1, 1'b1, 400);
    wait_lv(1, 1'b0, 100);
    frame(c);
  endtask : fresh
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 8'h10, '0, 32'h0, 32'hFFFFFFFF);
    // every scale point, then random codes
    for (int i = 0; i < 14; i++) begin
      fresh(i < 11 ? tbl[i] : 10'($random(seed)));
    end
    $display("test scale done");
    fresh(10'h0C8);
    check("lockout", 32'h0, {31'h0, lockout});
    repeat (320) @(posedge mclk);
    // select during an automatic conversion: value must not move
    wait_lv(1, 1'b1, 400);
    temp_sample <= 10'h190;
    frame(10'h0C8);
    check("lockout", 32'h1, {31'h0, lockout});
    frame(10'h0C8);
    check("lockout", 32'h1, {31'h0, lockout});
    repeat (700) @(posedge mclk);
    check("lockout", 32'h0, {31'h0, lockout});
    wait_lv(1, 1'b1, 400);
    wait_lv(1, 1'b0, 100);
    frame(10'h190);
    $display("test lockout done");
    repeat (4) @(posedge mclk);
    check("notes left", 32'h0, 32'(exp_q.size()));
    complete_run();
  end
endmodule : temp_sensor_serial_readout_tb_top
